// *** sdc_regs.vh ***
// Constants for the synthesizer divider configuration logic
`ifndef SDC_REGS_VH
`define SDC_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SDC_OFF_CTRL      8'h00
`define SDC_OFF_DIVSTAT   8'h04
`define SDC_OFF_SELSTAT   8'h08
`define SDC_OFF_SHIFT     8'h0c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SDC_CTRL_SOFT_RST 0
`define SDC_DS_M_LSB      0
`define SDC_DS_N_LSB      9
`define SDC_DS_T_LSB      12
`define SDC_DS_SERIAL     14
`define SDC_DS_RESET      15
`define SDC_DS_NVAL_LSB   16
`define SDC_SS_XTAL       0
`define SDC_SS_BYPASS     1
`define SDC_SS_MONITOR    2

// ----------------------------------------
// Widths and serial word layout
// ----------------------------------------
`define SDC_M_W           9
`define SDC_N_W           3
`define SDC_T_W           2
`define SDC_SR_W          14
`define SDC_SR_T_LSB      12
`define SDC_SR_N_LSB      9
`define SDC_SR_M_LSB      0
`define SDC_NOUT          2
`define SDC_ODIV_W        5

// ----------------------------------------
// Reset values (match pin pull defaults)
// ----------------------------------------
`define SDC_M_RST         9'h100
`define SDC_N_RST         3'h4
`define SDC_T_RST         2'h0
`define SDC_CTRL_RST      1'h0
// Pin vector: {bypass, xtal, n[2:0], m[8:0], mr, sload, sdata, sclk, pload_n}
`define SDC_PIN_W         19
`define SDC_PIN_RST       19'h72000
// Bypass select level that means bypass mode
`define SDC_BYPASS_LEVEL  1'b0

`endif

// *** sdc_out_div.v ***
// Output divider producing 50 percent duty true and complement outputs
`timescale 1ns/1ps
`include "sdc_regs.vh"

module sdc_out_div (
	// Clock and reset
	input  wire                       clk,
	input  wire                       rst_n,
	input  wire                       div_rst,
	// Tap of the power-of-two counter
	input  wire [2:0]                 tap_sel,
	// Outputs
	output reg  [`SDC_NOUT-1:0]       out_true_r,
	output reg  [`SDC_NOUT-1:0]       out_comp_r,
	output reg                        out_cmos_r
);

	reg  [`SDC_ODIV_W-1:0] cnt_r;
	wire                   tap_bit;

	assign tap_bit = cnt_r[tap_sel];

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 5'h00;
		end else if (div_rst) begin
			cnt_r <= 5'h00;
		end else begin
			cnt_r <= cnt_r + 5'h01;
		end
	end

	// ----------------------------------------
	// Output stages
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `SDC_NOUT; gi = gi + 1) begin : g_out
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					out_true_r[gi] <= 1'b0;
					out_comp_r[gi] <= 1'b1;
				end else if (div_rst) begin
					out_true_r[gi] <= 1'b0;
					out_comp_r[gi] <= 1'b1;
				end else begin
					out_true_r[gi] <= tap_bit;
					out_comp_r[gi] <= ~tap_bit;
				end
			end
		end
	endgenerate

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_cmos_r <= 1'b0;
		end else if (div_rst) begin
			out_cmos_r <= 1'b0;
		end else begin
			out_cmos_r <= tap_bit;
		end
	end

endmodule

// *** sdc_config.v ***
// Divider configuration logic of the synthesizer with APB status access
//
// Notes on behaviour
// - Divider reset high holds dividers reset: true outputs low, complements high.
// - Divider reset overrides the divisor settings at both dividers and forces true outputs low and complements high.
// - Divider reset leaves stored feedback, output and monitor values untouched.
// - Parallel strobe low passes divisor pins through; monitor output low.
// - Parallel strobe rise with load low captures pins and holds them.
// - Parallel strobe high, load low: shift serial bit each serial clock rise.
// - Serial load rise transfers shift register into both dividers.
// - Serial load fall latches current divisor values and holds them.
// - Without serial clock edge, pin changes leave the shift register alone.
// - Serial load held high: dividers follow serial data each clock rise.
// - Feedback divisor is 9-bit unsigned; host programs 125 to 350.
// - Output code 0..7 divides by 2,4,8,16,1,2,4,8.
// - Reference select high picks crystal, low picks alternate clock.
// - Bypass select chooses loop or bypass mode; level is a define.
// - Serial path also loads two monitor-select bits held internally.
// - Monitor: 00 low, 01 serial bit, 10 feedback divider, 11 synth out.
// - Output divider yields 50 percent duty for every setting.
`timescale 1ns/1ps
`include "sdc_regs.vh"

module sdc_config (
	// APB
	input  wire                       pclk,
	input  wire                       presetn,
	input  wire                       psel,
	input  wire                       penable,
	input  wire                       pwrite,
	input  wire [7:0]                 paddr,
	input  wire [31:0]                pwdata,
	output reg  [31:0]                prdata,
	output reg                        pready,
	output reg                        pslverr,
	// Configuration pins
	input  wire                       global_divider_reset,
	input  wire                       parallel_latch_strobe_n,
	input  wire [`SDC_M_W-1:0]        feedback_divisor_bits,
	input  wire [`SDC_N_W-1:0]        output_divisor_bits,
	input  wire                       serial_shift_clock,
	input  wire                       serial_data_in,
	input  wire                       serial_load_strobe,
	input  wire                       reference_source_select,
	input  wire                       loop_bypass_select,
	// Synthesizer outputs
	output wire [`SDC_NOUT-1:0]       synth_out_true,
	output wire [`SDC_NOUT-1:0]       synth_out_complement,
	output reg                        monitor_out,
	output reg                        ref_is_crystal,
	output reg                        bypass_mode,
	output reg  [`SDC_M_W-1:0]        feedback_divisor_active,
	output reg  [`SDC_N_W-1:0]        output_divisor_active
);

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------
	// Counter tap: tap k divides the base tick by 2^k
	function [2:0] n_tap;
		input [2:0] code;
		begin
			case (code)
				3'h0:    n_tap = 3'h1;
				3'h1:    n_tap = 3'h2;
				3'h2:    n_tap = 3'h3;
				3'h3:    n_tap = 3'h4;
				3'h4:    n_tap = 3'h0;
				3'h5:    n_tap = 3'h1;
				3'h6:    n_tap = 3'h2;
				default: n_tap = 3'h3;
			endcase
		end
	endfunction

	function [4:0] n_value;
		input [2:0] code;
		begin
			n_value = 5'h01 << n_tap(code);
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire [`SDC_PIN_W-1:0] pin_raw;
	reg  [`SDC_PIN_W-1:0] pin_s1_r;
	reg  [`SDC_PIN_W-1:0] pin_s2_r;
	reg  [`SDC_PIN_W-1:0] pin_d_r;
	localparam [`SDC_PIN_W-1:0] pin_dflt = `SDC_PIN_RST;

	assign pin_raw = {loop_bypass_select, reference_source_select, output_divisor_bits,
	                  feedback_divisor_bits, global_divider_reset, serial_load_strobe,
	                  serial_data_in, serial_shift_clock, parallel_latch_strobe_n};

	genvar gi;
	generate
		for (gi = 0; gi < `SDC_PIN_W; gi = gi + 1) begin : g_sync
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pin_s1_r[gi] <= pin_dflt[gi];
					pin_s2_r[gi] <= pin_dflt[gi];
					pin_d_r[gi]  <= pin_dflt[gi];
				end else begin
					pin_s1_r[gi] <= pin_raw[gi];
					pin_s2_r[gi] <= pin_s1_r[gi];
					pin_d_r[gi]  <= pin_s2_r[gi];
				end
			end
		end
	endgenerate

	wire                 pload_n  = pin_s2_r[0];
	wire                 sclk     = pin_s2_r[1];
	wire                 sdat     = pin_s2_r[2];
	wire                 sload    = pin_s2_r[3];
	wire                 mr_pin   = pin_s2_r[4];
	wire [`SDC_M_W-1:0]  m_pin    = pin_s2_r[13:5];
	wire [`SDC_N_W-1:0]  n_pin_w  = pin_s2_r[16:14];
	wire                 xtal_pin = pin_s2_r[17];

	wire pload_rise = pload_n & ~pin_d_r[0];
	wire sclk_rise  = sclk & ~pin_d_r[1];
	wire sload_rise = sload & ~pin_d_r[3];

	// ----------------------------------------
	// Configuration state
	// ----------------------------------------
	reg  [`SDC_SR_W-1:0] shift_r;
	reg  [`SDC_SR_W-1:0] shift_nxt;
	reg  [`SDC_M_W-1:0]  m_r;
	reg  [`SDC_N_W-1:0]  n_r;
	reg  [`SDC_T_W-1:0]  t_r;
	reg                  sbit_r;
	reg                  soft_rst_r;
	reg                  div_rst_r;
	wire                 serial_mode = pload_n;

	// New bit enters at the bottom, first bit ends at top
	always @* begin
		shift_nxt = {shift_r[`SDC_SR_W-2:0], sdat};
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shift_r <= 14'h0000;
			sbit_r  <= 1'b0;
		end else if (serial_mode && sclk_rise) begin
			shift_r <= shift_nxt;
			sbit_r  <= sdat;
		end
	end

	// Divisor and monitor-select registers; divider reset does not touch them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_r <= `SDC_M_RST;
			n_r <= `SDC_N_RST;
			t_r <= `SDC_T_RST;
		end else if (!serial_mode) begin
			m_r <= m_pin;
			n_r <= n_pin_w;
		end else if (pload_rise && !sload) begin
			m_r <= m_pin;
			n_r <= n_pin_w;
		end else if (sload_rise) begin
			m_r <= shift_r[`SDC_SR_M_LSB +: `SDC_M_W];
			n_r <= shift_r[`SDC_SR_N_LSB +: `SDC_N_W];
			t_r <= shift_r[`SDC_SR_T_LSB +: `SDC_T_W];
		end else if (sload && sclk_rise) begin
			m_r <= shift_nxt[`SDC_SR_M_LSB +: `SDC_M_W];
			n_r <= shift_nxt[`SDC_SR_N_LSB +: `SDC_N_W];
			t_r <= shift_nxt[`SDC_SR_T_LSB +: `SDC_T_W];
		end
		// Divider reset is not a term here
	end

	// ----------------------------------------
	// Divider reset
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_rst_r <= 1'b1;
		end else begin
			div_rst_r <= mr_pin | soft_rst_r;
		end
	end

	// ----------------------------------------
	// Feedback divider
	// ----------------------------------------
	reg                  vco_r;
	reg  [`SDC_M_W-1:0]  fb_cnt_r;
	reg                  fb_out_r;
	wire                 vco_tick = ~vco_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vco_r    <= 1'b0;
			fb_cnt_r <= 9'h000;
			fb_out_r <= 1'b0;
		end else if (div_rst_r) begin
			vco_r    <= 1'b0;
			fb_cnt_r <= 9'h000;
			fb_out_r <= 1'b0;
		end else begin
			vco_r <= ~vco_r;
			if (vco_tick) begin
				if (fb_cnt_r >= m_r - 9'h001) begin
					fb_cnt_r <= 9'h000;
				end else begin
					fb_cnt_r <= fb_cnt_r + 9'h001;
				end
				fb_out_r <= (fb_cnt_r < {1'b0, m_r[`SDC_M_W-1:1]});
			end
		end
	end

	// ----------------------------------------
	// Output divider
	// ----------------------------------------
	wire synth_cmos;

	sdc_out_div u_out_div (
		.clk        (pclk),
		.rst_n      (presetn),
		.div_rst    (div_rst_r),
		.tap_sel    (n_tap(n_r)),
		.out_true_r (synth_out_true),
		.out_comp_r (synth_out_complement),
		.out_cmos_r (synth_cmos)
	);

	// ----------------------------------------
	// Monitor and selection outputs
	// ----------------------------------------
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			monitor_out             <= 1'b0;
			ref_is_crystal          <= 1'b1;
			bypass_mode             <= 1'b0;
			feedback_divisor_active <= `SDC_M_RST;
			output_divisor_active   <= `SDC_N_RST;
		end else begin
			if (!serial_mode) begin
				monitor_out <= 1'b0;
			end else begin
				case (t_r)
					2'h0:    monitor_out <= 1'b0;
					2'h1:    monitor_out <= sbit_r;
					2'h2:    monitor_out <= fb_out_r;
					default: monitor_out <= synth_cmos;
				endcase
			end
			ref_is_crystal <= xtal_pin;
			bypass_mode    <= (pin_s2_r[`SDC_PIN_W-1] == `SDC_BYPASS_LEVEL);
			feedback_divisor_active <= m_r;
			output_divisor_active   <= n_r;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	wire        apb_acc  = psel & penable & ~pready;
	wire        apb_done = psel & penable & pready;
	reg  [31:0] rd_nxt;
	reg         err_nxt;

	always @* begin
		rd_nxt  = 32'h0000_0000;
		err_nxt = 1'b0;
		case (paddr)
			`SDC_OFF_CTRL: begin
				rd_nxt[`SDC_CTRL_SOFT_RST] = soft_rst_r;
			end
			`SDC_OFF_DIVSTAT: begin
				rd_nxt[`SDC_DS_M_LSB +: `SDC_M_W] = m_r;
				rd_nxt[`SDC_DS_N_LSB +: `SDC_N_W] = n_r;
				rd_nxt[`SDC_DS_T_LSB +: `SDC_T_W] = t_r;
				rd_nxt[`SDC_DS_SERIAL]            = serial_mode;
				rd_nxt[`SDC_DS_RESET]             = div_rst_r;
				rd_nxt[`SDC_DS_NVAL_LSB +: 5]     = n_value(n_r);
			end
			`SDC_OFF_SELSTAT: begin
				rd_nxt[`SDC_SS_XTAL]    = ref_is_crystal;
				rd_nxt[`SDC_SS_BYPASS]  = bypass_mode;
				rd_nxt[`SDC_SS_MONITOR] = monitor_out;
			end
			`SDC_OFF_SHIFT: begin
				rd_nxt[`SDC_SR_W-1:0] = shift_r;
			end
			default: begin
				err_nxt = 1'b1;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h0000_0000;
			soft_rst_r <= `SDC_CTRL_RST;
		end else begin
			pready <= apb_acc;
			if (apb_acc) begin
				pslverr <= err_nxt | (pwrite & (paddr != `SDC_OFF_CTRL) & ~err_nxt);
				prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
			end else begin
				pslverr <= 1'b0;
				prdata  <= 32'h0000_0000;
			end
			if (apb_done && pwrite && (paddr == `SDC_OFF_CTRL)) begin
				soft_rst_r <= pwdata[`SDC_CTRL_SOFT_RST];
			end
		end
	end

endmodule

// *** sdc_config_chk.sv ***
// Port checker for the divider configuration logic
`timescale 1ns/1ps
`include "sdc_regs.vh"

module sdc_chk (
	// Bus
	input logic             pclk,
	input logic             presetn,
	input logic             psel,
	input logic             penable,
	input logic             pready,
	// Pins
	input logic             global_divider_reset,
	input logic             parallel_latch_strobe_n,
	input logic [`SDC_M_W-1:0] feedback_divisor_bits,
	input logic             serial_load_strobe,
	input logic             reference_source_select,
	input logic             loop_bypass_select,
	// Outputs
	input logic [`SDC_NOUT-1:0] synth_out_true,
	input logic [`SDC_NOUT-1:0] synth_out_complement,
	input logic             monitor_out,
	input logic             ref_is_crystal,
	input logic             bypass_mode,
	input logic [`SDC_M_W-1:0] feedback_divisor_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_access;
		psel && penable && !pready;
	endsequence
	sequence s_reset_held;
		global_divider_reset[*6];
	endsequence
	a_apb_one_wait: assert property (s_access |=> pready ##1 !pready) else $error("pready timing");
	a_reset_out_low: assert property (s_reset_held |-> synth_out_true == 2'h0) else $error("out not low");
	a_out_pair_inv: assert property (synth_out_complement == ~synth_out_true) else $error("pair");
	a_par_pass_m: assert property ((!parallel_latch_strobe_n && $stable(feedback_divisor_bits))[*6]
		|-> feedback_divisor_active == feedback_divisor_bits) else $error("no pass");
	a_par_mon_low: assert property ((!parallel_latch_strobe_n)[*6] |-> !monitor_out) else $error("mon");
	a_ser_hold_m: assert property ((parallel_latch_strobe_n && !serial_load_strobe)[*6]
		|-> $stable(feedback_divisor_active)) else $error("m moved");
	a_ref_sel_map: assert property ($stable(reference_source_select)[*6]
		|-> ref_is_crystal == reference_source_select) else $error("ref");
	a_bypass_sel_map: assert property ($stable(loop_bypass_select)[*6]
		|-> bypass_mode == (loop_bypass_select == `SDC_BYPASS_LEVEL)) else $error("bypass");
endmodule

bind sdc_config sdc_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .global_divider_reset,
	.parallel_latch_strobe_n, .feedback_divisor_bits, .serial_load_strobe, .reference_source_select,
	.loop_bypass_select, .synth_out_true, .synth_out_complement, .monitor_out, .ref_is_crystal,
	.bypass_mode, .feedback_divisor_active);

// *** sdc_host.sv ***
// Host model driving the configuration pins
`timescale 1ns/1ps

module sdc_host (
	// Clock
	input  logic       pclk,
	// Pins
	output logic       global_divider_reset = 1'b0,
	output logic       parallel_latch_strobe_n = 1'b0,
	output logic [8:0] feedback_divisor_bits = 9'h100,
	output logic [2:0] output_divisor_bits = 3'h4,
	output logic       serial_shift_clock = 1'b0,
	output logic       serial_data_in = 1'b0,
	output logic       serial_load_strobe = 1'b0,
	output logic       reference_source_select = 1'b1,
	output logic       loop_bypass_select = 1'b1
);
	task automatic step(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic par(input logic [8:0] m, input logic [2:0] n, input logic latch);
		parallel_latch_strobe_n <= 1'b0;
		feedback_divisor_bits <= m;
		output_divisor_bits <= n;
		step(6);
		parallel_latch_strobe_n <= latch;
		step(6);
	endtask
	task automatic shift(input logic [13:0] w, input logic hold);
		parallel_latch_strobe_n <= 1'b1;
		step(6);
		feedback_divisor_bits <= 9'h1ff;
		output_divisor_bits <= 3'h7;
		serial_load_strobe <= hold;
		for (int i = 13; i >= 0; i--) begin
			serial_data_in <= w[i];
			step(4);
			serial_shift_clock <= 1'b1;
			step(4);
			serial_shift_clock <= 1'b0;
		end
		// Released line sinks to pull-down
		serial_data_in <= 1'b0;
		step(6);
	endtask
	task automatic load;
		serial_load_strobe <= 1'b1;
		step(6);
		serial_load_strobe <= 1'b0;
		step(6);
	endtask
endmodule

// *** tb.sv ***
// Self-checking bench for the divider configuration logic
`timescale 1ns/1ps
`include "sdc_regs.vh"

module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, r;
	logic        pready, pslverr, e, monitor_out, ref_is_crystal, bypass_mode;
	logic        global_divider_reset, parallel_latch_strobe_n, serial_shift_clock, serial_data_in;
	logic        serial_load_strobe, reference_source_select, loop_bypass_select;
	logic [8:0]  feedback_divisor_bits, feedback_divisor_active;
	logic [2:0]  output_divisor_bits, output_divisor_active;
	logic [1:0]  synth_out_true, synth_out_complement;
	int          mismatches = 0;
	int          checked = 0;
	int          hi, tg;
	logic [4:0]  ndiv [8] = '{5'h02, 5'h04, 5'h08, 5'h10, 5'h01, 5'h02, 5'h04, 5'h08};

	always #12.5 pclk = ~pclk;

	sdc_host u_host (.pclk, .global_divider_reset, .parallel_latch_strobe_n, .feedback_divisor_bits,
		.output_divisor_bits, .serial_shift_clock, .serial_data_in, .serial_load_strobe,
		.reference_source_select, .loop_bypass_select);
	sdc_config i_sdc_config (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .global_divider_reset, .parallel_latch_strobe_n, .feedback_divisor_bits,
		.output_divisor_bits, .serial_shift_clock, .serial_data_in, .serial_load_strobe,
		.reference_source_select, .loop_bypass_select, .synth_out_true, .synth_out_complement,
		.monitor_out, .ref_is_crystal, .bypass_mode, .feedback_divisor_active, .output_divisor_active);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		wt(1);
		penable <= 1'b1;
		n = 0;
		do begin
			wt(1);
			n++;
		end while (pready !== 1'b1 && n < 9);
		if (n == 9) begin
			mismatches++;
			end_of_test();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		wt(1);
	endtask
	function automatic logic [31:0] dstat(input logic [8:0] m, input logic [2:0] n,
		input logic [1:0] t, input logic s);
		return {11'h0, ndiv[n], 1'b0, s, t, n, m};
	endfunction
	task automatic meas(input logic m, input int n);
		logic p, s;
		p = m ? monitor_out : synth_out_true[0];
		hi = 0;
		tg = 0;
		repeat (n) begin
			wt(1);
			s = m ? monitor_out : synth_out_true[0];
			hi += s;
			tg += (s != p);
			p = s;
		end
	endtask

	task automatic t_regs;
		apb(1'b0, `SDC_OFF_DIVSTAT, 32'h0);
		chk(r, dstat(9'h100, 3'h4, 2'h0, 1'b0));
		chk(e, 1'b0);
		apb(1'b0, `SDC_OFF_SELSTAT, 32'h0);
		chk(r, 32'h1);
		apb(1'b1, `SDC_OFF_CTRL, 32'h1);
		wt(4);
		chk({synth_out_true, synth_out_complement}, 4'h3);
		apb(1'b0, `SDC_OFF_CTRL, 32'h0);
		chk(r, 32'h1);
		apb(1'b1, `SDC_OFF_CTRL, 32'h0);
		apb(1'b1, `SDC_OFF_SHIFT, 32'h5);
		chk(e, 1'b1);
		apb(1'b0, 8'h10, 32'h0);
		chk(e, 1'b1);
		chk(r, 32'h0);
	endtask
	task automatic t_par;
		for (int c = 0; c < 8; c++) begin
			u_host.par(9'd125 + 9'(c), 3'(c), 1'b0);
			apb(1'b0, `SDC_OFF_DIVSTAT, 32'h0);
			chk(r, dstat(9'd125 + 9'(c), 3'(c), 2'h0, 1'b0));
			meas(1'b0, 64);
			chk(tg, 64 / ndiv[c]);
			chk(hi, 32);
		end
		u_host.par(9'd350, 3'h4, 1'b0);
		chk(feedback_divisor_active, 9'd350);
	endtask
	task automatic t_latch;
		u_host.par(9'd200, 3'h1, 1'b1);
		u_host.feedback_divisor_bits <= 9'd50;
		u_host.output_divisor_bits <= 3'h6;
		u_host.global_divider_reset <= 1'b1;
		wt(8);
		chk({feedback_divisor_active, output_divisor_active}, {9'd200, 3'h1});
		chk({synth_out_true, synth_out_complement}, 4'h3);
		u_host.global_divider_reset <= 1'b0;
		wt(8);
		chk({feedback_divisor_active, output_divisor_active}, {9'd200, 3'h1});
	endtask
	task automatic t_serial;
		u_host.shift({2'b01, 3'h2, 9'd301}, 1'b0);
		apb(1'b0, `SDC_OFF_SHIFT, 32'h0);
		chk(r, {18'h0, 2'b01, 3'h2, 9'd301});
		chk(feedback_divisor_active, 9'd200);
		u_host.load();
		apb(1'b0, `SDC_OFF_DIVSTAT, 32'h0);
		chk(r, dstat(9'd301, 3'h2, 2'h1, 1'b1));
		chk(monitor_out, 1'b1);
	endtask
	task automatic t_direct;
		u_host.shift({2'b11, 3'h0, 9'd125}, 1'b1);
		chk({feedback_divisor_active, output_divisor_active}, {9'd125, 3'h0});
		meas(1'b1, 64);
		chk(tg, 32);
		u_host.shift({2'b10, 3'h0, 9'd125}, 1'b1);
		meas(1'b1, 1000);
		chk(tg != 0, 1'b1);
		u_host.shift({2'b00, 3'h0, 9'd125}, 1'b1);
		meas(1'b1, 16);
		chk(hi, 0);
		u_host.serial_load_strobe <= 1'b0;
		wt(8);
	endtask
	task automatic t_sel;
		for (int i = 0; i < 4; i++) begin
			u_host.reference_source_select <= i[0];
			u_host.loop_bypass_select <= i[1];
			wt(8);
			chk(ref_is_crystal, i[0]);
			chk(bypass_mode, i[1] == `SDC_BYPASS_LEVEL);
		end
	endtask

	initial begin
		wt(20);
		presetn <= 1'b1;
		wt(8);
		t_regs();
		t_par();
		t_latch();
		t_serial();
		t_direct();
		t_sel();
		end_of_test();
	end
endmodule
